// >>> hdl/btc_ctrl.sv
// Notes on behaviour
// - Transmit request moves one byte from RAM
// - Receive request moves one byte into RAM
// - Count done raises CPU interrupt
// - Upper count byte decrements once per transfer in repeat mode
// - Size zero is byte, mode one repeat
// - Source fixed at zero, increments at two
// - Destination fixed at zero, increments at two
// - Interrupt only at end; no chain when clear
// - Address mode zero uses full addresses
// - Per-vector activation enable for receive, transmit
// - Disabled peripheral interrupt never activates transfers
// - Pointer fetched from vector table entry
// - Repeat expiry restores walked address, count
// - Four longwords full, three short 24-bit
// - Vector base in 4 KB steps
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module btc_ctrl (
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rst_n_in,
   // Register port
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [31:0] reg_rdata_out,
   // Serial port requests and their interrupt enables
   input  wire logic        rx_full_request_in,
   input  wire logic        tx_empty_request_in,
   input  wire logic        rx_irq_enable_in,
   input  wire logic        tx_irq_enable_in,
   // Bus master toward RAM and the serial port
   output logic      [31:0] mem_addr_out,
   output logic      [31:0] mem_wdata_out,
   output logic      [3:0]  mem_be_out,
   output logic             mem_we_out,
   output logic             mem_re_out,
   input  wire logic [31:0] mem_rdata_in,
   // Interrupts
   output logic             cpu_rx_irq_out,
   output logic             cpu_tx_irq_out,
   output logic             irq_out
);
   typedef enum logic [3:0] {
      S_IDLE, S_PTR_W, S_INF, S_INF_W, S_SRC, S_SRC_W, S_DST, S_UPD, S_WB, S_END
   } btc_state_t;

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic [31:0] ctrl_q, ctrl_d;
   logic [31:0] vbase_q, vbase_d;
   logic [1:0]  acten_q, acten_d;
   logic [31:0] rdata_d;
   logic [1:0]  stat;
   logic [1:0]  mask;
   logic        stat_rd;
   logic        mask_wr;
   logic        start;
   logic        short_md;
   btc_state_t  st_q, st_d;
   logic [7:0]  vec_q, vec_d;

   assign start    = ctrl_q[btc_pkg::CTRL_START_BIT];
   assign short_md = ctrl_q[btc_pkg::CTRL_SHORT_BIT];
   assign stat_rd  = reg_rd_in && (reg_addr_in == btc_pkg::REG_STAT);
   assign mask_wr  = reg_wr_in && (reg_addr_in == btc_pkg::REG_MASK);

   always_comb begin
      ctrl_d  = ctrl_q;
      vbase_d = vbase_q;
      acten_d = acten_q;
      rdata_d = 32'h0000_0000;
      if (reg_wr_in) begin
         case (reg_addr_in)
            btc_pkg::REG_CTRL:  ctrl_d  = {30'h0, reg_wdata_in[1:0]};
            btc_pkg::REG_VBASE: vbase_d = {reg_wdata_in[31:12], 12'h000};
            btc_pkg::REG_ACTEN: acten_d = reg_wdata_in[1:0];
            default:            ;
         endcase
      end
      if (reg_rd_in) begin
         case (reg_addr_in)
            btc_pkg::REG_CTRL:  rdata_d = ctrl_q;
            btc_pkg::REG_VBASE: rdata_d = vbase_q;
            btc_pkg::REG_ACTEN: rdata_d = {30'h0, acten_q};
            btc_pkg::REG_STAT:  rdata_d = {30'h0, stat};
            btc_pkg::REG_MASK:  rdata_d = {30'h0, mask};
            btc_pkg::REG_STATE: rdata_d = {16'h0, vec_q, 7'h00, st_q != S_IDLE};
            default:            rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         ctrl_q        <= btc_pkg::CTRL_RST;
         vbase_q       <= btc_pkg::VBASE_RST;
         acten_q       <= btc_pkg::ACTEN_RST;
         reg_rdata_out <= 32'h0000_0000;
      end else begin
         ctrl_q        <= ctrl_d;
         vbase_q       <= vbase_d;
         acten_q       <= acten_d;
         reg_rdata_out <= rdata_d;
      end
   end

   // ------------------------------------------------------------
   // Activation and interrupt units
   // ------------------------------------------------------------
   btc_act_if act_if ();

   btc_arb u_arb (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .start_in   (start),
      .act_en_in  (acten_q),
      .irq_en_in  ({tx_irq_enable_in, rx_irq_enable_in}),
      .req_in     ({tx_empty_request_in, rx_full_request_in}),
      .act        (act_if)
   );

   btc_irq u_irq (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .evt_in     ({cpu_tx_irq_out, cpu_rx_irq_out}),
      .stat_rd_in (stat_rd),
      .mask_wr_in (mask_wr),
      .mask_in    (reg_wdata_in[1:0]),
      .stat_out   (stat),
      .mask_out   (mask),
      .irq_out    (irq_out)
   );

   // ------------------------------------------------------------
   // Transfer sequencer
   // ------------------------------------------------------------
   logic [2:0]  idx_q, idx_d;
   logic [31:0] ptr_q, ptr_d;
   logic [7:0]  mra_q, mra_d;
   logic [7:0]  mrb_q, mrb_d;
   logic [31:0] sar_q, sar_d;
   logic [31:0] dar_q, dar_d;
   logic [15:0] cra_q, cra_d;
   logic [15:0] crb_q, crb_d;
   logic [31:0] data_q, data_d;
   logic        end_q, end_d;
   logic [31:0] addr_d, wdata_d;
   logic [3:0]  be_d;
   logic        we_d, re_d, rxi_d, txi_d;
   logic [31:0] iw [4];
   logic [31:0] sar_n, dar_n;
   logic [7:0]  count_upper_byte_n;
   logic [2:0]  last;
   logic [1:0]  sm, sz, md, dm;

   assign sm   = mra_q[btc_pkg::MRA_SM_LSB +: 2];
   assign sz   = mra_q[btc_pkg::MRA_SZ_LSB +: 2];
   assign md   = mra_q[btc_pkg::MRA_MD_LSB +: 2];
   assign dm   = mrb_q[btc_pkg::MRB_DM_LSB +: 2];
   assign last = short_md ? btc_pkg::LAST_SHORT : btc_pkg::LAST_FULL;

   // Short mode packs the mode words above 24-bit addresses.
   always_comb begin
      if (short_md) begin
         iw[0] = {mra_q, sar_q[23:0]};
         iw[1] = {mrb_q, dar_q[23:0]};
         iw[2] = {cra_q, crb_q};
         iw[3] = 32'h0000_0000;
      end else begin
         iw[0] = {mra_q, mrb_q, 16'h0000};
         iw[1] = sar_q;
         iw[2] = dar_q;
         iw[3] = {cra_q, crb_q};
      end
   end

   always_comb begin
      st_d    = st_q;
      idx_d   = idx_q;
      ptr_d   = ptr_q;
      vec_d   = vec_q;
      mra_d   = mra_q;
      mrb_d   = mrb_q;
      sar_d   = sar_q;
      dar_d   = dar_q;
      cra_d   = cra_q;
      crb_d   = crb_q;
      data_d  = data_q;
      end_d   = end_q;
      addr_d  = mem_addr_out;
      wdata_d = mem_wdata_out;
      be_d    = mem_be_out;
      we_d    = 1'b0;
      re_d    = 1'b0;
      rxi_d   = 1'b0;
      txi_d   = 1'b0;
      sar_n   = btc_pkg::step_addr(sar_q, sm, sz);
      dar_n   = btc_pkg::step_addr(dar_q, dm, sz);
      count_upper_byte_n  = cra_q[15:8] - 8'h01;
      act_if.take = 1'b0;
      case (st_q)
         S_IDLE: begin
            if (start && act_if.valid) begin
               act_if.take = 1'b1;
               vec_d  = act_if.vec;
               re_d   = 1'b1;
               addr_d = {vbase_q[31:12], 2'b00, act_if.vec, 2'b00};
               st_d   = S_PTR_W;
            end
         end
         S_PTR_W: begin
            ptr_d = mem_rdata_in;
            idx_d = 3'h0;
            st_d  = S_INF;
         end
         S_INF: begin
            re_d   = 1'b1;
            addr_d = ptr_q + {27'h0, idx_q, 2'b00};
            st_d   = S_INF_W;
         end
         S_INF_W: begin
            if (short_md) begin
               case (idx_q)
                  3'h0: begin
                     mra_d = mem_rdata_in[31:24];
                     sar_d = {{8{mem_rdata_in[23]}}, mem_rdata_in[23:0]};
                  end
                  3'h1: begin
                     mrb_d = mem_rdata_in[31:24];
                     dar_d = {{8{mem_rdata_in[23]}}, mem_rdata_in[23:0]};
                  end
                  default: {cra_d, crb_d} = mem_rdata_in;
               endcase
            end else begin
               case (idx_q)
                  3'h0:    {mra_d, mrb_d} = mem_rdata_in[31:16];
                  3'h1:    sar_d = mem_rdata_in;
                  3'h2:    dar_d = mem_rdata_in;
                  default: {cra_d, crb_d} = mem_rdata_in;
               endcase
            end
            idx_d = idx_q + 3'h1;
            st_d  = (idx_q == last) ? S_SRC : S_INF;
         end
         S_SRC: begin
            re_d   = 1'b1;
            addr_d = sar_q;
            st_d   = S_SRC_W;
         end
         S_SRC_W: begin
            data_d = mem_rdata_in >> {sar_q[1:0], 3'b000};
            st_d   = S_DST;
         end
         S_DST: begin
            we_d    = 1'b1;
            addr_d  = dar_q;
            wdata_d = data_q << {dar_q[1:0], 3'b000};
            be_d    = btc_pkg::lane_mask(sz) << dar_q[1:0];
            st_d    = S_UPD;
         end
         S_UPD: begin
            sar_d = sar_n;
            dar_d = dar_n;
            if (md == btc_pkg::MD_REPEAT) begin
               end_d = (count_upper_byte_n == 8'h00);
               if (count_upper_byte_n == 8'h00) begin
                  cra_d = {cra_q[7:0], cra_q[7:0]};
                  sar_d = btc_pkg::rewind(sar_n, sm, sz, cra_q[7:0]);
                  dar_d = btc_pkg::rewind(dar_n, dm, sz, cra_q[7:0]);
               end else begin
                  cra_d = {count_upper_byte_n, cra_q[7:0]};
               end
            end else begin
               cra_d = cra_q - 16'h0001;
               end_d = (cra_q == 16'h0001);
            end
            idx_d = short_md ? 3'h0 : 3'h1;
            st_d  = S_WB;
         end
         S_WB: begin
            we_d    = 1'b1;
            be_d    = 4'hF;
            addr_d  = ptr_q + {27'h0, idx_q, 2'b00};
            wdata_d = iw[idx_q[1:0]];
            idx_d   = idx_q + 3'h1;
            st_d    = (idx_q == last) ? S_END : S_WB;
         end
         S_END: begin
            if (end_q || mrb_q[btc_pkg::MRB_IRQ_SELECT_BIT]) begin
               rxi_d = (vec_q == btc_pkg::VEC_RX);
               txi_d = (vec_q == btc_pkg::VEC_TX);
            end
            if (mrb_q[btc_pkg::MRB_CHAIN_ENABLE_BIT] && !end_q) begin
               ptr_d = ptr_q + (short_md ? btc_pkg::INFO_SHORT_BYTES
                                         : btc_pkg::INFO_FULL_BYTES);
               idx_d = 3'h0;
               st_d  = S_INF;
            end else begin
               st_d = S_IDLE;
            end
         end
         default: st_d = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         st_q           <= S_IDLE;
         idx_q          <= 3'h0;
         ptr_q          <= 32'h0000_0000;
         vec_q          <= 8'h00;
         mra_q          <= 8'h00;
         mrb_q          <= 8'h00;
         sar_q          <= 32'h0000_0000;
         dar_q          <= 32'h0000_0000;
         cra_q          <= 16'h0000;
         crb_q          <= 16'h0000;
         data_q         <= 32'h0000_0000;
         end_q          <= 1'b0;
         mem_addr_out   <= 32'h0000_0000;
         mem_wdata_out  <= 32'h0000_0000;
         mem_be_out     <= 4'h0;
         mem_we_out     <= 1'b0;
         mem_re_out     <= 1'b0;
         cpu_rx_irq_out <= 1'b0;
         cpu_tx_irq_out <= 1'b0;
      end else begin
         st_q           <= st_d;
         idx_q          <= idx_d;
         ptr_q          <= ptr_d;
         vec_q          <= vec_d;
         mra_q          <= mra_d;
         mrb_q          <= mrb_d;
         sar_q          <= sar_d;
         dar_q          <= dar_d;
         cra_q          <= cra_d;
         crb_q          <= crb_d;
         data_q         <= data_d;
         end_q          <= end_d;
         mem_addr_out   <= addr_d;
         mem_wdata_out  <= wdata_d;
         mem_be_out     <= be_d;
         mem_we_out     <= we_d;
         mem_re_out     <= re_d;
         cpu_rx_irq_out <= rxi_d;
         cpu_tx_irq_out <= txi_d;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   vec_fetch_a: assert property (st_q == S_IDLE && act_if.take |=>
      mem_re_out && mem_addr_out == {vbase_q[31:12], 2'b00, vec_q, 2'b00})
      else $error("vector table entry address wrong");
   tx_move_a: assert property (st_q == S_SRC |=>
      mem_re_out && mem_addr_out == sar_q ##2 mem_we_out && mem_addr_out == dar_q)
      else $error("unit move did not read source then write destination");
   rx_move_a: assert property (st_q == S_SRC && vec_q == btc_pkg::VEC_RX &&
      sz == btc_pkg::SZ_BYTE |=> !mem_we_out ##2 mem_we_out && $onehot(mem_be_out))
      else $error("receive byte not written as a single lane");
   byte_lane_a: assert property (mem_we_out && st_q == S_UPD &&
      sz == btc_pkg::SZ_BYTE |-> mem_be_out == (4'h1 << dar_q[1:0]))
      else $error("byte transfer used wrong lane");
   end_irq_a: assert property (st_q == S_END && end_q |=>
      cpu_rx_irq_out || cpu_tx_irq_out)
      else $error("no interrupt at transfer end");
   quiet_end_a: assert property (st_q == S_END && !end_q &&
      !mrb_q[btc_pkg::MRB_IRQ_SELECT_BIT] |=> !cpu_rx_irq_out && !cpu_tx_irq_out)
      else $error("interrupt raised before transfer end");
   count_dec_a: assert property (st_q == S_UPD && md == btc_pkg::MD_REPEAT &&
      cra_q[15:8] != 8'h01 |=> cra_q[15:8] == $past(cra_q[15:8]) - 8'h01)
      else $error("repeat count not decremented by one");
   rewind_a: assert property (st_q == S_UPD && md == btc_pkg::MD_REPEAT &&
      cra_q[15:8] == 8'h01 |=> cra_q[15:8] == cra_q[7:0] && end_q)
      else $error("repeat count not restored");
   src_hold_a: assert property (st_q == S_UPD && sm == btc_pkg::AM_FIXED |=>
      sar_q == $past(sar_q))
      else $error("fixed source address moved");
   dst_inc_a: assert property (st_q == S_UPD && dm == btc_pkg::AM_INC &&
      cra_q[15:8] != 8'h01 |=> dar_q == $past(dar_q) + (32'h0000_0001 << sz))
      else $error("destination not incremented");
   idle_hold_a: assert property (st_q == S_IDLE && !start |=> st_q == S_IDLE)
      else $error("activation while module stopped");

   rx_move_c: cover property (st_q == S_SRC && vec_q == btc_pkg::VEC_RX);
   tx_end_c: cover property (cpu_tx_irq_out);
   chain_c: cover property (st_q == S_END ##1 st_q == S_INF);
endmodule : btc_ctrl

// >>> shared/btc_pkg.sv
package btc_pkg;

   // ------------------------------------------------------------
   // Register offsets and fields
   // ------------------------------------------------------------
   localparam logic [7:0]  REG_CTRL         = 8'h00;
   localparam logic [7:0]  REG_VBASE        = 8'h04;
   localparam logic [7:0]  REG_ACTEN        = 8'h08;
   localparam logic [7:0]  REG_STAT         = 8'h0C;
   localparam logic [7:0]  REG_MASK         = 8'h10;
   localparam logic [7:0]  REG_STATE        = 8'h14;
   localparam int          CTRL_START_BIT   = 0;
   localparam int          CTRL_SHORT_BIT   = 1;
   localparam int          VBASE_LSB        = 12;
   localparam logic [31:0] CTRL_RST         = 32'h0000_0000;
   localparam logic [31:0] VBASE_RST        = 32'h0000_0000;
   localparam logic [1:0]  ACTEN_RST        = 2'h0;
   localparam logic [1:0]  MASK_RST         = 2'h0;

   // ------------------------------------------------------------
   // Activation vectors
   // ------------------------------------------------------------
   localparam logic [7:0]  VEC_RX           = 8'hD6;
   localparam logic [7:0]  VEC_TX           = 8'hD7;

   // ------------------------------------------------------------
   // Transfer information layout
   // ------------------------------------------------------------
   localparam int          MRA_SM_LSB       = 2;
   localparam int          MRA_SZ_LSB       = 4;
   localparam int          MRA_MD_LSB       = 6;
   localparam int          MRB_DM_LSB       = 2;
   localparam int          MRB_IRQ_SELECT_BIT    = 5;
   localparam int          MRB_CHAIN_ENABLE_BIT     = 7;
   localparam logic [1:0]  SZ_BYTE          = 2'h0;
   localparam logic [1:0]  SZ_WORD          = 2'h1;
   localparam logic [1:0]  MD_NORMAL        = 2'h0;
   localparam logic [1:0]  MD_REPEAT        = 2'h1;
   localparam logic [1:0]  AM_FIXED         = 2'h0;
   localparam logic [1:0]  AM_INC           = 2'h2;
   localparam logic [1:0]  AM_DEC           = 2'h3;
   localparam logic [2:0]  LAST_FULL        = 3'h3;
   localparam logic [2:0]  LAST_SHORT       = 3'h2;
   localparam logic [31:0] INFO_FULL_BYTES  = 32'h0000_0010;
   localparam logic [31:0] INFO_SHORT_BYTES = 32'h0000_000C;

   // Address after one transfer unit.
   function automatic logic [31:0] step_addr(input logic [31:0] a,
                                             input logic [1:0] am,
                                             input logic [1:0] sz);
      logic [31:0] st;
      st = 32'h0000_0001 << sz;
      case (am)
         AM_INC:  step_addr = a + st;
         AM_DEC:  step_addr = a - st;
         default: step_addr = a;
      endcase
   endfunction : step_addr

   // Moves a walked address back over a full repeat area; zero counts as 256.
   function automatic logic [31:0] rewind(input logic [31:0] a,
                                          input logic [1:0] am,
                                          input logic [1:0] sz,
                                          input logic [7:0] n);
      logic [31:0] span;
      span = {23'h000000, (n == 8'h00), n} << sz;
      case (am)
         AM_INC:  rewind = a - span;
         AM_DEC:  rewind = a + span;
         default: rewind = a;
      endcase
   endfunction : rewind

   function automatic logic [3:0] lane_mask(input logic [1:0] sz);
      case (sz)
         SZ_BYTE: lane_mask = 4'h1;
         SZ_WORD: lane_mask = 4'h3;
         default: lane_mask = 4'hF;
      endcase
   endfunction : lane_mask

endpackage : btc_pkg

// >>> shared/btc_act_if.sv
`timescale 1ns/1ps
interface btc_act_if;
   logic       valid;
   logic [7:0] vec;
   logic       take;
   modport arb (output valid, output vec, input take);
   modport ctl (input valid, input vec, output take);
endinterface : btc_act_if

// >>> hdl/btc_arb.sv
`timescale 1ns/1ps
module btc_arb (
   // Clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       rst_n_in,
   // Gating
   input  wire logic       start_in,
   input  wire logic [1:0] act_en_in,
   input  wire logic [1:0] irq_en_in,
   // Requests, bit 0 receive, bit 1 transmit
   input  wire logic [1:0] req_in,
   // Toward the sequencer
   btc_act_if.arb          act
);
   logic [1:0] pend_q;
   logic [1:0] pend_d;
   logic [1:0] grant;

   assign grant     = pend_q[0] ? 2'h1 : 2'h2;
   assign act.valid = |pend_q;
   assign act.vec   = pend_q[0] ? btc_pkg::VEC_RX : btc_pkg::VEC_TX;

   // A request landing in the cycle its pending flag is taken stays pending.
   always_comb begin
      pend_d = pend_q;
      if (act.take) begin
         pend_d = pend_d & ~grant;
      end
      for (int i = 0; i < 2; i++) begin
         if (req_in[i] && irq_en_in[i] && act_en_in[i]) begin
            pend_d[i] = 1'b1;
         end
      end
      if (!start_in) begin
         pend_d = 2'h0;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         pend_q <= 2'h0;
      end else begin
         pend_q <= pend_d;
      end
   end
endmodule : btc_arb

// >>> hdl/btc_irq.sv
`timescale 1ns/1ps
module btc_irq (
   // Clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       rst_n_in,
   // Events and software access
   input  wire logic [1:0] evt_in,
   input  wire logic       stat_rd_in,
   input  wire logic       mask_wr_in,
   input  wire logic [1:0] mask_in,
   // State
   output logic      [1:0] stat_out,
   output logic      [1:0] mask_out,
   output logic            irq_out
);
   logic [1:0] stat_d;
   logic [1:0] mask_d;
   logic       irq_d;

   // An event in the reading cycle survives the read clear.
   always_comb begin
      stat_d = stat_out;
      if (stat_rd_in) begin
         stat_d = 2'h0;
      end
      stat_d = stat_d | evt_in;
      mask_d = mask_wr_in ? mask_in : mask_out;
      irq_d  = |(stat_d & mask_d);
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         stat_out <= 2'h0;
         mask_out <= btc_pkg::MASK_RST;
         irq_out  <= 1'b0;
      end else begin
         stat_out <= stat_d;
         mask_out <= mask_d;
         irq_out  <= irq_d;
      end
   end
endmodule : btc_irq

// >>> tb/btc_mem_model.sv
`timescale 1ns/1ps
// ---
// RAM and serial holding words
// ---
module btc_mem_model (
   // Clock
   input  wire logic        clk_sys_in,
   // Bus from the controller
   input  wire logic [31:0] mem_addr_in,
   input  wire logic [31:0] mem_wdata_in,
   input  wire logic [3:0]  mem_be_in,
   input  wire logic        mem_we_in,
   input  wire logic        mem_re_in,
   output logic      [31:0] mem_rdata_out,
   output int               n_wr_out
);
   logic [31:0] mem [0:255];
   initial begin
      n_wr_out = 0;
   end
   // The controller captures read data in the cycle its read strobe stands, so the word
   // follows the address then; all ones otherwise, so a capture in the wrong cycle shows.
   assign mem_rdata_out = mem_re_in ? mem[mem_addr_in[9:2]] : 32'hFFFF_FFFF;
   always @(posedge clk_sys_in) begin
      if (mem_we_in) begin
         n_wr_out <= n_wr_out + 1;
         for (int b = 0; b < 4; b++) begin
            if (mem_be_in[b]) begin
               mem[mem_addr_in[9:2]][8*b +: 8] <= mem_wdata_in[8*b +: 8];
            end
         end
      end
   end
endmodule : btc_mem_model

// >>> tb/test_byte_repeat_transfer_ctrl.sv
`timescale 1ns/1ps
module test_byte_repeat_transfer_ctrl;
   logic        clk_sys_in, rst_n_in, reg_wr, reg_rd, rx_req, tx_req, rx_en, tx_en;
   logic        mem_we, mem_re, rx_irq, tx_irq, irq;
   logic [7:0]  reg_addr;
   logic [3:0]  mem_be;
   logic [31:0] reg_wdata, rdata, mem_addr, mem_wdata, mem_rdata;
   int          n_fail, n_compared, n_wr, n_txi, n_rxi, cyc, w;

   btc_ctrl btc_ctrl_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
      .rx_full_request_in(rx_req), .tx_empty_request_in(tx_req), .rx_irq_enable_in(rx_en),
      .tx_irq_enable_in(tx_en), .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata),
      .mem_be_out(mem_be), .mem_we_out(mem_we), .mem_re_out(mem_re), .mem_rdata_in(mem_rdata),
      .cpu_rx_irq_out(rx_irq), .cpu_tx_irq_out(tx_irq), .irq_out(irq));
   btc_mem_model btc_mem_model_i (.clk_sys_in(clk_sys_in), .mem_addr_in(mem_addr),
      .mem_wdata_in(mem_wdata), .mem_be_in(mem_be), .mem_we_in(mem_we), .mem_re_in(mem_re),
      .mem_rdata_out(mem_rdata), .n_wr_out(n_wr));

   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end

   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (tx_irq === 1'b1) n_txi <= n_txi + 1;
      if (rx_irq === 1'b1) n_rxi <= n_rxi + 1;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict();
      end
   end

   // ---
   // Access tasks
   // ---
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr <= 1'b0;
   endtask : wr

   task rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys_in);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd <= 1'b0;
      #1;
      check(rdata, e);
   endtask : rchk

   // A transfer ends with four bus writes: the data unit and three write-backs.
   task req(input logic tx);
      int k;
      int w0;
      w0 = n_wr;
      k = 0;
      @(posedge clk_sys_in);
      tx_req <= tx;
      rx_req <= ~tx;
      @(posedge clk_sys_in);
      tx_req <= 1'b0;
      rx_req <= 1'b0;
      while (n_wr < w0 + 4 && k < 60) begin
         @(posedge clk_sys_in);
         k++;
      end
      repeat (5) @(posedge clk_sys_in);
      #1;
   endtask : req

   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   initial begin
      {rst_n_in, reg_wr, reg_rd, rx_req, tx_req, rx_en, tx_en} = 7'h03;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      repeat (5) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      rchk(btc_pkg::REG_CTRL, btc_pkg::CTRL_RST);
      rchk(btc_pkg::REG_ACTEN, 32'(btc_pkg::ACTEN_RST));
      rchk(8'h20, 32'h0000_0000);
      wr(btc_pkg::REG_VBASE, 32'h0000_1ABC);
      rchk(btc_pkg::REG_VBASE, 32'h0000_1000);
      $display("test registers done");
      for (int i = 0; i < 32; i++) begin
         btc_mem_model_i.mem[8'h80 + i / 4][8 * (i % 4) +: 8] = 8'hA0 + 8'(i);
      end
      btc_mem_model_i.mem[8'hD6] = 32'h0000_0110;
      btc_mem_model_i.mem[8'hD7] = 32'h0000_0100;
      {btc_mem_model_i.mem[8'h40], btc_mem_model_i.mem[8'h41], btc_mem_model_i.mem[8'h42],
       btc_mem_model_i.mem[8'h43]} = {32'h4800_0000, 32'h200, 32'h300, 32'h2020_0000};
      {btc_mem_model_i.mem[8'h44], btc_mem_model_i.mem[8'h45], btc_mem_model_i.mem[8'h46],
       btc_mem_model_i.mem[8'h47]} = {32'h4008_0000, 32'h304, 32'h280, 32'h2020_0000};
      wr(btc_pkg::REG_ACTEN, 32'h3);
      wr(btc_pkg::REG_MASK, 32'h2);
      w = n_wr;
      req(1'b1);
      check(32'(n_wr), 32'(w));
      wr(btc_pkg::REG_CTRL, 32'h1);
      tx_en <= 1'b0;
      req(1'b1);
      check(32'(n_wr), 32'(w));
      tx_en <= 1'b1;
      wr(btc_pkg::REG_ACTEN, 32'h1);
      req(1'b1);
      check(32'(n_wr), 32'(w));
      wr(btc_pkg::REG_ACTEN, 32'h3);
      $display("test gating done");
      for (int i = 0; i < 33; i++) begin
         req(1'b1);
         check(32'(btc_mem_model_i.mem[8'hC0][7:0]), 32'(8'hA0 + 8'(i % 32)));
         check(32'(n_txi), 32'(i >= 31));
      end
      check(32'(irq), 32'h1);
      rchk(btc_pkg::REG_STAT, 32'h2);
      repeat (2) @(posedge clk_sys_in);
      check(32'(irq), 32'h0);
      $display("test transmit done");
      for (int i = 0; i < 32; i++) begin
         btc_mem_model_i.mem[8'hC1] = {24'h00_0000, 8'h50 + 8'(i)};
         req(1'b0);
      end
      for (int i = 0; i < 32; i++) begin
         check(32'(btc_mem_model_i.mem[8'hA0 + i / 4][8 * (i % 4) +: 8]),
               32'(8'h50 + 8'(i)));
      end
      check(32'(n_rxi), 32'h1);
      check(32'(irq), 32'h0);
      rchk(btc_pkg::REG_STAT, 32'h1);
      wr(btc_pkg::REG_CTRL, 32'h0);
      w = n_wr;
      req(1'b0);
      check(32'(n_wr), 32'(w));
      $display("test receive done");
      print_verdict();
   end
endmodule : test_byte_repeat_transfer_ctrl
